/* rtl/tocmp_control.sv */
// compare-output and waveform-mode control with wishbone registers
// What this block does
// - a nonzero unit A mode field hands the unit A pin to the compare output, but 01 only in modes 0, 4, 9, 11, 12, 14 and 15.
// - a unit B mode field of 10 or 11, or 01 in modes 0, 4 and 12, hands the unit B pin to the compare output.
// - the two-bit mode field means different things per waveform family.
// - in non-PWM modes 00 disconnects, 01 toggles, 10 clears, 11 sets on match.
// - fast PWM with 01 toggles unit A only in modes 14 and 15, else disconnected.
// - fast PWM with 10 clears on match and sets at bottom.
// - fast PWM with 11 sets on match and clears at bottom.
// - fast PWM ignores a match at top when the upper mode bit is set.
// - dual-slope PWM with 01 toggles unit A only in modes 9 and 11.
// - dual-slope 10 clears on up match and sets on down match, 11 the reverse.
// - low and high mode bits together select the waveform mode.
// - mode 0 normal, 1-3 and 10-11 phase correct, 4 and 12 clear on match, 5-7 and
//           14-15 fast, 8-9 phase and frequency correct, 13 reserved.
// - dual-slope compare at bottom holds low, at top holds high, inverted opposite.
`timescale 1ns/10ps
`default_nettype none
module tocmp_control
   import tocmp_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // counter status from the timer core, same clock
   input  wire logic [15:0] count_value,
   input  wire logic [15:0] top_value,
   input  wire logic        count_tick,
   input  wire logic        count_down,
   // port pins
   input  wire logic [1:0]  port_data,
   input  wire logic [1:0]  port_direction,
   output logic             unit_a_compare_pin,
   output logic             unit_a_compare_pin_oe,
   output logic             unit_b_compare_pin,
   output logic             unit_b_compare_pin_oe
);
   import tocmp_pkg::*;

   logic [7:0]  timer_output_mode_control_reg;
   logic [1:0]  waveform_mode_high_bits_reg;
   logic [15:0] unit_a_compare_value_reg;
   logic [15:0] unit_b_compare_value_reg;
   logic [1:0]  wave_reg;
   logic [3:0]  waveform_mode_select;
   logic [1:0]  unit_a_output_mode;
   logic [1:0]  unit_b_output_mode;
   tocmp_family_type family;
   logic        bus_req;
   logic [1:0]  wave_next;
   logic        unit_a_toggle_ok;
   logic        unit_a_connected;
   logic        unit_b_connected;

   // a unit owns its pin whenever its mode field is nonzero, except 01 in a PWM or reserved mode without toggle
   function automatic logic pin_connected(input logic [1:0] om,
                                          input tocmp_family_type fam,
                                          input logic toggle_ok);
      pin_connected = (om != TOCMP_OM_OFF) &&
                      !((fam != TOCMP_FAM_NONPWM) && (om == TOCMP_OM_TOGGLE) && !toggle_ok);
   endfunction

   // decode waveform number into a family
   function automatic tocmp_family_type wm_family(input logic [3:0] wm);
      case (wm)
         4'h0, 4'h4, 4'hc: wm_family = TOCMP_FAM_NONPWM;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf: wm_family = TOCMP_FAM_FAST;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: wm_family = TOCMP_FAM_DUAL;
         default: wm_family = TOCMP_FAM_RSVD;
      endcase
   endfunction

   // one compare unit's next level
   function automatic logic unit_next(input logic cur, input logic [1:0] om,
                                      input tocmp_family_type fam, input logic [15:0] cmp,
                                      input logic [15:0] cnt, input logic [15:0] top,
                                      input logic down, input logic toggle_ok);
      logic match;
      match = (cmp == cnt);
      unit_next = cur;
      case (fam)
         TOCMP_FAM_NONPWM: begin
            if (match) begin
               case (om)
                  TOCMP_OM_TOGGLE: unit_next = ~cur;
                  TOCMP_OM_CLEAR:  unit_next = 1'b0;
                  TOCMP_OM_SET:    unit_next = 1'b1;
                  default:         unit_next = cur;
               endcase
            end
         end
         TOCMP_FAM_FAST: begin
            if (om == TOCMP_OM_TOGGLE) begin
               if (match && toggle_ok)
                  unit_next = ~cur;
            end else if (om[1]) begin
               if (cnt == TOCMP_BOTTOM)
                  unit_next = ~om[0];
               else if (match && cmp != top)
                  unit_next = om[0];
            end
         end
         TOCMP_FAM_DUAL: begin
            if (om == TOCMP_OM_TOGGLE) begin
               if (match && toggle_ok)
                  unit_next = ~cur;
            end else if (om[1]) begin
               if (cmp == TOCMP_BOTTOM)
                  unit_next = om[0];
               else if (cmp == top)
                  unit_next = ~om[0];
               else if (match)
                  unit_next = down ^ om[0];
            end
         end
         default: unit_next = cur;
      endcase
   endfunction

   // combine mode bits and split fields
   assign waveform_mode_select = {waveform_mode_high_bits_reg,
                                  timer_output_mode_control_reg[1:0]};
   assign family = wm_family(waveform_mode_select);
   assign unit_a_output_mode =
      timer_output_mode_control_reg[TOCMP_MODE_A_HI:TOCMP_MODE_A_LO];
   assign unit_b_output_mode =
      timer_output_mode_control_reg[TOCMP_MODE_B_HI:TOCMP_MODE_B_LO];
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // pwm toggle is only offered to unit A, and only in the modes that use it as top
   assign unit_a_toggle_ok = (waveform_mode_select == TOCMP_WM_FAST_I) ||
                             (waveform_mode_select == TOCMP_WM_FAST_A) ||
                             (waveform_mode_select == TOCMP_WM_PFC_A) ||
                             (waveform_mode_select == TOCMP_WM_PC_A);
   assign unit_a_connected = pin_connected(unit_a_output_mode, family,
                                           unit_a_toggle_ok);
   assign unit_b_connected = pin_connected(unit_b_output_mode, family,
                                           1'b0);

   // register writes, byte lanes 0 and 1 only
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         timer_output_mode_control_reg <= TOCMP_CTRL_RESET;
         waveform_mode_high_bits_reg   <= 2'h0;
         unit_a_compare_value_reg      <= 16'h0000;
         unit_b_compare_value_reg      <= 16'h0000;
      end else if (bus_req && wb_we_i) begin
         case (wb_adr_i)
            TOCMP_CTRL_ADDR: begin
               if (wb_sel_i[0])
                  timer_output_mode_control_reg <= wb_dat_i[7:0] & TOCMP_CTRL_WMASK;
            end
            TOCMP_HIGH_ADDR: begin
               if (wb_sel_i[0])
                  waveform_mode_high_bits_reg <= wb_dat_i[1:0];
            end
            TOCMP_CMPA_ADDR: begin
               if (wb_sel_i[0]) unit_a_compare_value_reg[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) unit_a_compare_value_reg[15:8] <= wb_dat_i[15:8];
            end
            TOCMP_CMPB_ADDR: begin
               if (wb_sel_i[0]) unit_b_compare_value_reg[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) unit_b_compare_value_reg[15:8] <= wb_dat_i[15:8];
            end
            default: ;
         endcase
      end
   end

   // bus answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               TOCMP_CTRL_ADDR: wb_dat_o <= {24'h00_0000, timer_output_mode_control_reg};
               TOCMP_HIGH_ADDR: wb_dat_o <= {30'h0, waveform_mode_high_bits_reg};
               TOCMP_CMPA_ADDR: wb_dat_o <= {16'h0000, unit_a_compare_value_reg};
               TOCMP_CMPB_ADDR: wb_dat_o <= {16'h0000, unit_b_compare_value_reg};
               default:         wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // waveform levels of both units
   always_comb begin
      wave_next = wave_reg;
      if (count_tick) begin
         wave_next[0] = unit_next(wave_reg[0], unit_a_output_mode, family,
                                  unit_a_compare_value_reg, count_value, top_value,
                                  count_down, unit_a_toggle_ok);
         wave_next[1] = unit_next(wave_reg[1], unit_b_output_mode, family,
                                  unit_b_compare_value_reg, count_value, top_value,
                                  count_down, 1'b0);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n)
         wave_reg <= 2'h0;
      else
         wave_reg <= wave_next;
   end

   // pin override and driver enable
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         unit_a_compare_pin    <= 1'b0;
         unit_b_compare_pin    <= 1'b0;
         unit_a_compare_pin_oe <= 1'b0;
         unit_b_compare_pin_oe <= 1'b0;
      end else begin
         unit_a_compare_pin <= unit_a_connected ? wave_next[0] : port_data[0];
         unit_b_compare_pin <= unit_b_connected ? wave_next[1] : port_data[1];
         unit_a_compare_pin_oe <= port_direction[0];
         unit_b_compare_pin_oe <= port_direction[1];
      end
   end

   // checks
   property p_ctrl_reserved;
      @(posedge mclk) disable iff (!reset_n)
      timer_output_mode_control_reg[3:2] == 2'h0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved)
      else $error("reserved control bits set");

   property p_pin_a_override;
      @(posedge mclk) disable iff (!reset_n)
      unit_a_connected |=> unit_a_compare_pin == wave_reg[0];
   endproperty
   a_pin_a_override: assert property (p_pin_a_override)
      else $error("unit A pin not from compare output");

   property p_pin_b_port;
      @(posedge mclk) disable iff (!reset_n)
      (unit_b_output_mode == TOCMP_OM_OFF) |=> unit_b_compare_pin == $past(port_data[1]);
   endproperty
   a_pin_b_port: assert property (p_pin_b_port)
      else $error("unit B pin not from port");

   property p_oe_dir;
      @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> unit_a_compare_pin_oe == $past(port_direction[0]);
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("driver enable ignores direction");

   property p_nonpwm_set;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_NONPWM && unit_a_output_mode == TOCMP_OM_SET &&
       unit_a_compare_value_reg == count_value) |=> wave_reg[0];
   endproperty
   a_nonpwm_set: assert property (p_nonpwm_set)
      else $error("set on match missed");

   property p_fast_bottom;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_FAST && unit_a_output_mode == TOCMP_OM_CLEAR &&
       count_value == TOCMP_BOTTOM) |=> wave_reg[0];
   endproperty
   a_fast_bottom: assert property (p_fast_bottom)
      else $error("fast non-inverted not set at bottom");

   property p_b_no_toggle;
      @(posedge mclk) disable iff (!reset_n)
      (family != TOCMP_FAM_NONPWM && unit_b_output_mode == TOCMP_OM_TOGGLE)
      |=> $stable(wave_reg[1]);
   endproperty
   a_b_no_toggle: assert property (p_b_no_toggle)
      else $error("unit B toggled in PWM");

   property p_dual_up_clear;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_DUAL && unit_a_output_mode == TOCMP_OM_CLEAR &&
       !count_down && unit_a_compare_value_reg == count_value &&
       count_value != top_value && count_value != TOCMP_BOTTOM) |=> !wave_reg[0];
   endproperty
   a_dual_up_clear: assert property (p_dual_up_clear)
      else $error("dual-slope up match did not clear");

   property p_rsvd_hold;
      @(posedge mclk) disable iff (!reset_n)
      (waveform_mode_select == TOCMP_WM_RSVD) |=> $stable(wave_reg);
   endproperty
   a_rsvd_hold: assert property (p_rsvd_hold)
      else $error("reserved mode changed output");

   // unit B driver enable follows its direction bit
   property p_oe_dir_b;
      @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> unit_b_compare_pin_oe == $past(port_direction[1]);
   endproperty
   a_oe_dir_b: assert property (p_oe_dir_b)
      else $error("unit B driver enable ignores direction");

   // fast inverted output sets on an ordinary match
   property p_fast_set_match;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_FAST && unit_a_output_mode == TOCMP_OM_SET &&
       unit_a_compare_value_reg == count_value && count_value != top_value &&
       count_value != TOCMP_BOTTOM) |=> wave_reg[0];
   endproperty
   a_fast_set_match: assert property (p_fast_set_match)
      else $error("fast inverted not set on match");

   // fast match at top is ignored when the upper mode bit is set
   property p_fast_top_ignored;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_FAST && unit_a_output_mode[1] &&
       unit_a_compare_value_reg == top_value && count_value == top_value &&
       count_value != TOCMP_BOTTOM) |=> $stable(wave_reg[0]);
   endproperty
   a_fast_top_ignored: assert property (p_fast_top_ignored)
      else $error("fast match at top changed output");

   // fast toggle outside modes 14 and 15 leaves unit A on its port
   property p_fast_a_disc;
      @(posedge mclk) disable iff (!reset_n)
      (family == TOCMP_FAM_FAST && unit_a_output_mode == TOCMP_OM_TOGGLE &&
       !unit_a_toggle_ok) |=> unit_a_compare_pin == $past(port_data[0]);
   endproperty
   a_fast_a_disc: assert property (p_fast_a_disc)
      else $error("unit A not on port in fast toggle");

   // dual-slope toggle never connects unit B
   property p_dual_b_port;
      @(posedge mclk) disable iff (!reset_n)
      (family == TOCMP_FAM_DUAL && unit_b_output_mode == TOCMP_OM_TOGGLE)
      |=> unit_b_compare_pin == $past(port_data[1]);
   endproperty
   a_dual_b_port: assert property (p_dual_b_port)
      else $error("unit B not on port in dual toggle");

   // dual-slope non-inverted down match sets the output
   property p_dual_down_set;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_DUAL && unit_a_output_mode == TOCMP_OM_CLEAR &&
       count_down && unit_a_compare_value_reg == count_value &&
       count_value != top_value && count_value != TOCMP_BOTTOM) |=> wave_reg[0];
   endproperty
   a_dual_down_set: assert property (p_dual_down_set)
      else $error("dual-slope down match did not set");

   // dual-slope compare at bottom holds a non-inverted output low
   property p_dual_bottom_low;
      @(posedge mclk) disable iff (!reset_n)
      (count_tick && family == TOCMP_FAM_DUAL && unit_a_output_mode == TOCMP_OM_CLEAR &&
       unit_a_compare_value_reg == TOCMP_BOTTOM) |=> !wave_reg[0];
   endproperty
   a_dual_bottom_low: assert property (p_dual_bottom_low)
      else $error("dual-slope compare at bottom not low");
endmodule
`default_nettype wire

/* rtl/tocmp_pkg.sv */
// constants for the timer compare-output control block
package tocmp_pkg;
   // register map, one aligned word each
   localparam logic [3:0] TOCMP_CTRL_ADDR = 4'h0;
   localparam logic [3:0] TOCMP_HIGH_ADDR = 4'h4;
   localparam logic [3:0] TOCMP_CMPA_ADDR = 4'h8;
   localparam logic [3:0] TOCMP_CMPB_ADDR = 4'hc;
   // control field layout
   localparam int TOCMP_MODE_A_HI = 7;
   localparam int TOCMP_MODE_A_LO = 6;
   localparam int TOCMP_MODE_B_HI = 5;
   localparam int TOCMP_MODE_B_LO = 4;
   localparam logic [7:0] TOCMP_CTRL_WMASK = 8'hf3;
   localparam logic [7:0] TOCMP_CTRL_RESET = 8'h00;
   // output mode encodings
   localparam logic [1:0] TOCMP_OM_OFF    = 2'h0;
   localparam logic [1:0] TOCMP_OM_TOGGLE = 2'h1;
   localparam logic [1:0] TOCMP_OM_CLEAR  = 2'h2;
   localparam logic [1:0] TOCMP_OM_SET    = 2'h3;
   // named waveform mode numbers, and the counter bottom value
   localparam logic [3:0] TOCMP_WM_NORMAL = 4'h0;
   localparam logic [3:0] TOCMP_WM_PFC_A  = 4'h9;
   localparam logic [3:0] TOCMP_WM_PC_A   = 4'hb;
   localparam logic [3:0] TOCMP_WM_RSVD   = 4'hd;
   localparam logic [3:0] TOCMP_WM_FAST_I = 4'he;
   localparam logic [3:0] TOCMP_WM_FAST_A = 4'hf;
   localparam logic [15:0] TOCMP_BOTTOM   = 16'h0000;
   // waveform family
   typedef enum logic [3:0] {
      TOCMP_FAM_NONPWM = 4'b0001,
      TOCMP_FAM_FAST   = 4'b0010,
      TOCMP_FAM_DUAL   = 4'b0100,
      TOCMP_FAM_RSVD   = 4'b1000
   } tocmp_family_type;
endpackage

/* testbench/tocmp_pad_model.sv */
// pad model: two port pins with pull-up loads
`timescale 1ns/10ps
`default_nettype none
module tocmp_pad_model (
   // drive from the block
   input  wire logic [1:0] pin,
   input  wire logic [1:0] pin_oe,
   // level on the pads
   output logic      [1:0] pad
);
   // an undriven pad floats up to the load's pull-up level
   assign pad[0] = pin_oe[0] ? pin[0] : 1'b1;
   assign pad[1] = pin_oe[1] ? pin[1] : 1'b1;
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the compare-output control block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import tocmp_pkg::*;
   logic        mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, ack;
   logic        tick = 0, down = 0, pin_chk = 0;
   logic [3:0]  adr = 0, sel = 0;
   logic [31:0] dat = 0, dat_o;
   logic [15:0] cnt = 0, top = 16'hffff, ca;
   logic [1:0]  pd = 0, dir = 0, pin, oe, pad;
   logic [31:0] q_dat[$];
   logic [5:0]  q_pin[$];
   logic [1:0]  oa_t[5] = '{3, 1, 2, 1, 0};
   logic [1:0]  ob_t[5] = '{2, 3, 1, 1, 2};
   logic [3:0]  wm_np[3] = '{0, 4, 12};
   logic [3:0]  wm_fp[5] = '{5, 6, 7, 14, 15};
   logic [3:0]  wm_ds[7] = '{1, 2, 3, 8, 9, 10, 11};
   int          n_errors = 0, n_tests = 0, cyc_cnt = 0;

   tocmp_control DUT (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .count_value(cnt), .top_value(top), .count_tick(tick),
      .count_down(down), .port_data(pd), .port_direction(dir),
      .unit_a_compare_pin(pin[0]), .unit_a_compare_pin_oe(oe[0]),
      .unit_b_compare_pin(pin[1]), .unit_b_compare_pin_oe(oe[1]));
   tocmp_pad_model pads (.pin(pin), .pin_oe(oe), .pad(pad));

   // clock and hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == 10000) begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task report_and_stop;
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // monitor: read data on ack, pins on a check strobe
   always @(posedge mclk) begin
      if (ack === 1'b1 && we === 1'b0) check(dat_o, q_dat.pop_front());
      if (pin_chk) check({26'h0, pin, pad, oe}, {26'h0, q_pin.pop_front()});
   end

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      q_dat.push_back(e);
      wb(1'b0, a, 4'hf, 32'h0);
   endtask

   task automatic cfg(input logic [1:0] oa, input logic [1:0] ob, input logic [3:0] wm);
      wb(1'b1, TOCMP_CTRL_ADDR, 4'h1, {24'h0, oa, ob, 2'b00, wm[1:0]});
      wb(1'b1, TOCMP_HIGH_ADDR, 4'h1, {30'h0, wm[3:2]});
   endtask

   task automatic cmp(input logic [15:0] a, input logic [15:0] b);
      wb(1'b1, TOCMP_CMPA_ADDR, 4'h3, {16'h0, a});
      wb(1'b1, TOCMP_CMPB_ADDR, 4'h3, {16'h0, b});
   endtask

   // one counter step, then the expected pins, pads and enables
   task automatic step(input logic [15:0] c, input logic d, input logic pa, input logic pb);
      @(posedge mclk);
      cnt  <= c;
      down <= d;
      tick <= 1'b1;
      dir  <= 2'($urandom);
      @(posedge mclk);
      tick <= 1'b0;
      q_pin.push_back({pb, pa, dir[1] ? pb : 1'b1, dir[0] ? pa : 1'b1, dir});
      pin_chk <= 1'b1;
      @(posedge mclk);
      pin_chk <= 1'b0;
   endtask

   // next pin state on a non-PWM match
   function automatic logic nx(input logic [1:0] om, input logic s);
      case (om)
         TOCMP_OM_TOGGLE: return ~s;
         TOCMP_OM_CLEAR: return 1'b0;
         TOCMP_OM_SET: return 1'b1;
         default: return s;
      endcase
   endfunction

   // main sequence
   initial begin
      logic sa;
      logic sb;
      void'($urandom(31596));
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      pd      <= 2'($urandom);
      ca = 16'h0100 + 16'($urandom_range(16'h7eff));
      rd(TOCMP_CTRL_ADDR, 32'h0);
      wb(1'b1, TOCMP_CTRL_ADDR, 4'h1, 32'hff);
      rd(TOCMP_CTRL_ADDR, {24'h0, TOCMP_CTRL_WMASK});
      rd(4'h2, 32'h0);
      cmp(ca, ca);
      rd(TOCMP_CMPB_ADDR, {16'h0, ca});
      // non-PWM: every output mode on unit A, all but 00 on unit B
      foreach (wm_np[w]) begin
         sa = 1'b0;
         sb = 1'b0;
         for (int k = 0; k < 5; k++) begin
            cfg(oa_t[k], ob_t[k], wm_np[w]);
            sa = nx(oa_t[k], sa);
            sb = nx(ob_t[k], sb);
            step(ca, 1'b0, oa_t[k] == 0 ? pd[0] : sa, ob_t[k] == 0 ? pd[1] : sb);
         end
      end
      // fast PWM: clear or set on match, reverse at bottom
      foreach (wm_fp[w]) begin
         cfg(TOCMP_OM_CLEAR, TOCMP_OM_SET, wm_fp[w]);
         step(ca, 1'b0, 1'b0, 1'b1);
         step(16'h0, 1'b0, 1'b1, 1'b0);
      end
      top <= ca;
      step(ca, 1'b0, 1'b1, 1'b0);
      step(16'h0, 1'b0, 1'b1, 1'b0);
      top <= 16'hffff;
      cfg(TOCMP_OM_TOGGLE, TOCMP_OM_TOGGLE, TOCMP_WM_FAST_I);
      step(ca, 1'b0, 1'b0, pd[1]);
      cfg(TOCMP_OM_TOGGLE, TOCMP_OM_TOGGLE, TOCMP_WM_FAST_A);
      step(ca, 1'b0, 1'b1, pd[1]);
      cfg(TOCMP_OM_TOGGLE, TOCMP_OM_TOGGLE, 4'h5);
      step(ca, 1'b0, pd[0], pd[1]);
      // dual-slope: action depends on count direction
      foreach (wm_ds[w]) begin
         cfg(TOCMP_OM_CLEAR, TOCMP_OM_SET, wm_ds[w]);
         step(ca, 1'b0, 1'b0, 1'b1);
         step(ca, 1'b1, 1'b1, 1'b0);
      end
      cfg(TOCMP_OM_TOGGLE, TOCMP_OM_TOGGLE, TOCMP_WM_PFC_A);
      step(ca, 1'b0, 1'b0, pd[1]);
      cfg(TOCMP_OM_TOGGLE, TOCMP_OM_TOGGLE, TOCMP_WM_PC_A);
      step(ca, 1'b1, 1'b1, pd[1]);
      cfg(TOCMP_OM_TOGGLE, TOCMP_OM_TOGGLE, 4'ha);
      step(ca, 1'b0, pd[0], pd[1]);
      // dual-slope extremes: compare at bottom and at top
      cmp(TOCMP_BOTTOM, 16'hffff);
      cfg(TOCMP_OM_CLEAR, TOCMP_OM_CLEAR, 4'h8);
      step(16'h0005, 1'b0, 1'b0, 1'b1);
      cfg(TOCMP_OM_SET, TOCMP_OM_SET, 4'h8);
      step(16'h0005, 1'b1, 1'b1, 1'b0);
      repeat (3) @(posedge mclk);
      report_and_stop();
   end
endmodule
`default_nettype wire
